// file: rtl/sfpi_core.sv
// Pin-level serial interface of a small serial flash device.
`timescale 1ns/100ps
`include "sfpi_defs.svh"
module sfpi_core (
    input wire logic clock, // 50 MHz system clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic cs_n, // Chip select pin, active low.
    input wire logic sck, // Serial clock pin.
    input wire logic si, // Serial data-in pin.
    input wire logic hold_n, // Hold pin, active low.
    input wire logic wp_n, // Write protect pin, active low.
    output logic so, // Serial data-out value.
    output logic so_oe, // Data-out drive enable, high while driving.
    input wire sfpi_pkg::sfpi_byte_t tx_data, // Next byte to shift out.
    output sfpi_pkg::sfpi_byte_t rx_byte, // Last received byte.
    output logic rx_valid, // Pulse: rx_byte is new.
    output logic rx_first, // rx_byte is the command byte of the frame.
    output logic frame_end, // Pulse: chip select went high.
    output logic frame_ok, // With frame_end: whole bytes were clocked.
    input wire logic wr_busy, // A program, erase or status write is running.
    output logic active, // Active power state, low in standby.
    input wire sfpi_pkg::sfpi_bp_t block_protect_field, // Protected area code.
    input wire logic wr_req, // Pulse: request to modify wr_addr.
    input wire sfpi_pkg::sfpi_addr_t wr_addr, // Address to be modified.
    output logic wr_go, // Pulse: modification allowed.
    output logic wr_blocked // Pulse: modification refused by protection.
);
    import sfpi_pkg::*;

    logic [4:0] pins_s;
    logic cs_s, sck_s, si_s, hold_s, wp_s;
    logic sck_prev_r, cs_prev_r;
    logic armed_r;
    logic [2:0] bit_cnt_r;
    logic byte_seen_r;
    logic first_r;
    sfpi_byte_t rx_sh_r, tx_sh_r;
    sfpi_state_e state_r;
    logic rise, fall, cs_fall, cs_rise, run;
    logic prot_hit;

    ////////////////////////////////////////////////////////////////////////
    // Every pin is asynchronous to clock; the serial clock at 160 ns gives
    // eight system cycles per period, enough for synchronised edge finding.
    // Select history resets low, so a select pin held low through reset shows
    // no falling edge; only a real high-to-low transition can arm the device.
    sfpi_sync #(
        .W(5),
        .RST_VAL({`SFPI_CS_RST, `SFPI_SCK_RST, 1'b0, `SFPI_HOLD_RST, `SFPI_WP_RST})
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .d({cs_n, sck, si, hold_n, wp_n}),
        .q(pins_s)
    );
    assign {cs_s, sck_s, si_s, hold_s, wp_s} = pins_s;

    // Edge history of the synchronised clock and select.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_prev_r <= `SFPI_SCK_RST;
            cs_prev_r <= `SFPI_CS_RST;
        end else begin
            sck_prev_r <= sck_s;
            cs_prev_r <= cs_s;
        end
    end

    // Edges of the serial clock count only while selected and not held.
    assign cs_fall = cs_prev_r && !cs_s;
    assign cs_rise = !cs_prev_r && cs_s;
    assign run = (state_r == SFPI_SEL) && hold_s && !cs_s && armed_r;
    assign rise = run && !sck_prev_r && sck_s;
    assign fall = run && sck_prev_r && !sck_s;

    ////////////////////////////////////////////////////////////////////////
    // Nothing is accepted until a select falling edge is seen after reset,
    // so a select already low at power-up is not mistaken for a frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            armed_r <= 1'b0;
        end else if (cs_fall) begin
            armed_r <= 1'b1;
        end
    end

    // Select and hold states; hold is honoured only while selected.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= SFPI_IDLE;
        end else begin
            unique case (state_r)
                SFPI_IDLE: begin
                    if (cs_fall && hold_s) begin
                        state_r <= SFPI_SEL;
                    end
                end
                SFPI_SEL: begin
                    if (cs_s) begin
                        state_r <= SFPI_IDLE;
                    end else if (!hold_s) begin
                        state_r <= SFPI_HOLD;
                    end
                end
                SFPI_HOLD: begin
                    if (cs_s) begin
                        state_r <= SFPI_IDLE;
                    end else if (hold_s) begin
                        state_r <= SFPI_SEL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit counter and receive shifter; hold freezes both, so the transfer
    // picks up at the same bit, and deselect clears the count.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt_r <= 3'h0;
            rx_sh_r <= 8'h00;
            byte_seen_r <= 1'b0;
        end else if (cs_s) begin
            bit_cnt_r <= 3'h0;
            byte_seen_r <= 1'b0;
        end else if (rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            rx_sh_r <= {rx_sh_r[6:0], si_s};
            if (bit_cnt_r == 3'h7) begin
                byte_seen_r <= 1'b1;
            end
        end
    end

    // Completed bytes are handed on; the first of each frame is marked.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            rx_first <= 1'b0;
            first_r <= 1'b1;
        end else begin
            rx_valid <= 1'b0;
            if (cs_s) begin
                first_r <= 1'b1;
            end else if (rise && bit_cnt_r == 3'h7) begin
                rx_byte <= {rx_sh_r[6:0], si_s};
                rx_valid <= 1'b1;
                rx_first <= first_r;
                first_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output shifter: a new byte is taken at each byte boundary except the start of a mode 0 frame, so data
    // out is always byte aligned; the bit changes only after a falling edge.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_sh_r <= 8'h00;
            so <= 1'b0;
        end else if (fall) begin
            if (bit_cnt_r == 3'h0) begin
                so <= tx_data[7];
                tx_sh_r <= {tx_data[6:0], 1'b0};
            end else begin
                so <= tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
        end
    end

    // Data-out is driven only while selected and not held.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            so_oe <= 1'b0;
        end else begin
            so_oe <= !cs_s && hold_s && armed_r && (state_r != SFPI_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame end report: writes may execute only on a whole-byte frame.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frame_end <= 1'b0;
            frame_ok <= 1'b0;
        end else begin
            frame_end <= cs_rise && armed_r;
            frame_ok <= cs_rise && armed_r && byte_seen_r && (bit_cnt_r == 3'h0);
        end
    end

    // Power state: a running write keeps the part active after deselect.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
        end else begin
            active <= !cs_s || wr_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protected area: always the top of the array, sized by the field.
    always_comb begin
        unique case (block_protect_field)
            3'h0: prot_hit = 1'b0;
            3'h1: prot_hit = wr_addr >= `SFPI_PROT_BASE1;
            3'h2: prot_hit = wr_addr >= `SFPI_PROT_BASE2;
            3'h3: prot_hit = wr_addr >= `SFPI_PROT_BASE3;
            3'h4: prot_hit = wr_addr >= `SFPI_PROT_BASE4;
            3'h5: prot_hit = wr_addr >= `SFPI_PROT_BASE5;
            default: prot_hit = wr_addr >= `SFPI_PROT_ALL;
        endcase
    end

    // Protection grants or refuses each modify request one cycle later.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_go <= 1'b0;
            wr_blocked <= 1'b0;
        end else begin
            wr_go <= wr_req && !(prot_hit && !wp_s);
            wr_blocked <= wr_req && prot_hit && !wp_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    AST_NO_DRIVE_DESEL: assert property (@(posedge clock) disable iff (rst)
        cs_s |=> !so_oe) else $error("data-out driven while deselected");
    AST_HOLD_FLOAT: assert property (@(posedge clock) disable iff (rst)
        !hold_s |=> !so_oe) else $error("data-out driven during hold");
    AST_HOLD_FREEZE: assert property (@(posedge clock) disable iff (rst)
        (!hold_s && !cs_s) |=> $stable(bit_cnt_r)) else $error("count moved in hold");
    AST_NOT_ARMED: assert property (@(posedge clock) disable iff (rst)
        !armed_r |-> !rise && !fall) else $error("edge used before arming");
    AST_CNT_CLEAR: assert property (@(posedge clock) disable iff (rst)
        cs_s |=> bit_cnt_r == 3'h0) else $error("count not cleared");
    AST_BYTE_DONE: assert property (@(posedge clock) disable iff (rst)
        (rise && bit_cnt_r == 3'h7) |=> rx_valid && rx_byte[0] == $past(si_s))
        else $error("byte not delivered");
    AST_FRAME_OK: assert property (@(posedge clock) disable iff (rst)
        frame_ok |-> frame_end && $past(bit_cnt_r) == 3'h0) else $error("bad frame ok");
    AST_ACTIVE: assert property (@(posedge clock) disable iff (rst)
        (!cs_s || wr_busy) |=> active) else $error("standby while busy");
    AST_PROTECT: assert property (@(posedge clock) disable iff (rst)
        (wr_req && prot_hit && !wp_s) |=> wr_blocked && !wr_go)
        else $error("protected write allowed");
    AST_SO_FALL: assert property (@(posedge clock) disable iff (rst)
        !fall |=> $stable(so)) else $error("data-out changed off a falling edge");
    COV_BYTE: cover property (@(posedge clock) disable iff (rst) rx_valid && rx_first);
    COV_HOLD: cover property (@(posedge clock) disable iff (rst)
        state_r == SFPI_HOLD ##1 state_r == SFPI_SEL);
    COV_BLOCK: cover property (@(posedge clock) disable iff (rst) wr_blocked);
    COV_OK: cover property (@(posedge clock) disable iff (rst) frame_ok);
endmodule // sfpi_core

// file: rtl/sfpi_defs.svh
// Constants for the serial flash pin interface.
`ifndef SFPI_DEFS_SVH
`define SFPI_DEFS_SVH
`define SFPI_BYTE_BITS 4'h8
`define SFPI_ADDR_W 19
`define SFPI_CS_RST 1'b0
`define SFPI_HOLD_RST 1'b1
`define SFPI_WP_RST 1'b1
`define SFPI_SCK_RST 1'b0
`define SFPI_PROT_BASE1 19'h7c000
`define SFPI_PROT_BASE2 19'h78000
`define SFPI_PROT_BASE3 19'h70000
`define SFPI_PROT_BASE4 19'h60000
`define SFPI_PROT_BASE5 19'h40000
`define SFPI_PROT_ALL 19'h00000
`endif

// file: rtl/sfpi_pkg.sv
// Types for the serial flash pin interface.
package sfpi_pkg;
    typedef enum logic [2:0] {
        SFPI_IDLE = 3'b001,
        SFPI_SEL = 3'b010,
        SFPI_HOLD = 3'b100
    } sfpi_state_e;
    typedef logic [7:0] sfpi_byte_t;
    typedef logic [2:0] sfpi_bp_t;
    typedef logic [18:0] sfpi_addr_t;
endpackage

// file: rtl/sfpi_sync.sv
// Two-stage synchroniser, one lane per bit.
`timescale 1ns/100ps
module sfpi_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic [W-1:0] d, // Asynchronous inputs.
    output logic [W-1:0] q // Synchronised outputs.
);
    genvar i;
    ////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second stage of the same lane.
    generate
        for (i = 0; i < W; i++) begin : g_lane
            logic meta_r;
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    meta_r <= RST_VAL[i];
                    q[i] <= RST_VAL[i];
                end else begin
                    meta_r <= d[i];
                    q[i] <= meta_r;
                end
            end
        end
    endgenerate
endmodule // sfpi_sync

// file: tb/serial_flash_pin_interface_tb.sv
// Self-checking bench for the serial flash pin interface.
`timescale 1ns/100ps
`include "sfpi_defs.svh"
module serial_flash_pin_interface_tb;
    import sfpi_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cs_n, sck, si, hold_n, so, so_oe, so_pin;
    logic so_last = 1'b0;
    logic wp_n = 1'b1;
    logic wr_busy = 1'b0;
    logic wr_req = 1'b0;
    logic rx_valid, rx_first, frame_end, frame_ok, active, wr_go, wr_blocked;
    sfpi_byte_t tx_data = 8'h00;
    sfpi_byte_t rx_byte;
    sfpi_bp_t bp = 3'h0;
    sfpi_addr_t wr_addr = 19'h00000;
    logic [8:0] rxq[$];
    logic okq[$];
    logic saw_oe = 1'b0;
    int hold_cnt = 0;
    int error_cnt = 0;
    int n_compared = 0;
    always #10 clock = ~clock;
    // A floated wire has no pull, so it shows the inverse of the last driven bit.
    assign so_pin = so_oe ? so : ~so_last;
    sfpi_master m (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
        .so_pin(so_pin));
    sfpi_core uut (.clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe), .tx_data(tx_data),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_first(rx_first),
        .frame_end(frame_end), .frame_ok(frame_ok), .wr_busy(wr_busy), .active(active),
        .block_protect_field(bp), .wr_req(wr_req), .wr_addr(wr_addr), .wr_go(wr_go),
        .wr_blocked(wr_blocked));
    // Collect pulses and watch the drive enable during long holds.
    always @(posedge clock) begin
        if (so_oe === 1'b1) so_last <= so;
        if (rx_valid === 1'b1) rxq.push_back({rx_first, rx_byte});
        if (frame_end === 1'b1) okq.push_back(frame_ok);
        hold_cnt <= (hold_n === 1'b0) ? hold_cnt + 1 : 0;
        if (hold_cnt > 5 && so_oe !== 1'b0) saw_oe <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [8:0] e, input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk1(input logic e, input logic g);
        chk({8'h00, e}, {8'h00, g});
    endtask
    function automatic sfpi_addr_t base_of(input sfpi_bp_t b);
        case (b)
            3'h1: return `SFPI_PROT_BASE1;
            3'h2: return `SFPI_PROT_BASE2;
            3'h3: return `SFPI_PROT_BASE3;
            3'h4: return `SFPI_PROT_BASE4;
            3'h5: return `SFPI_PROT_BASE5;
            default: return `SFPI_PROT_ALL;
        endcase
    endfunction
    // Expected {blocked, go}; code zero never protects anything.
    function automatic logic [1:0] prot(input logic w, input sfpi_bp_t b, input sfpi_addr_t a);
        return (!w && b != 3'h0 && a >= base_of(b)) ? 2'b10 : 2'b01;
    endfunction
    // One frame: nb whole bytes, an optional partial tail, an optional hold in the last byte.
    task automatic frame(input logic mode3, input int nb, input int extra, input logic hld);
        logic [7:0] d, q1, q2, got;
        logic [8:0] exp[$];
        tx_data = 8'($urandom);
        m.start(mode3);
        chk1(1'b1, active);
        chk1(1'b1, so_oe);
        for (int k = 0; k < nb; k++) begin
            d = 8'($urandom);
            if (hld && k == nb - 1) begin
                m.bits(d, 3, q1);
                m.pause();
                m.bits({d[4:0], 3'h0}, 5, q2);
                got = {q1[2:0], q2[4:0]};
            end else begin
                m.bits(d, 8, got);
            end
            if (k > 0) chk({1'b0, tx_data}, {1'b0, got});
            exp.push_back({k == 0, d});
        end
        if (extra > 0) m.bits(8'($urandom), extra, got);
        m.stop();
        repeat (6) @(negedge clock);
        chk1(1'b0, so_oe);
        chk(9'(exp.size()), 9'(rxq.size()));
        while (exp.size() > 0 && rxq.size() > 0) chk(exp.pop_front(), rxq.pop_front());
        chk1(nb > 0 && extra == 0, okq.size() == 1 ? okq.pop_front() : 1'bx);
        rxq.delete();
        okq.delete();
        $display("test frame mode3=%0d bytes=%0d done", mode3, nb);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence: unarmed traffic, power states, frames, then protection.
    initial begin
        logic [7:0] g;
        void'($urandom(32'hfcf12e72));
        repeat (12) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (4) @(negedge clock);
        m.bits(8'($urandom), 8, g);
        m.stop();
        repeat (6) @(negedge clock);
        chk(9'h000, 9'(rxq.size() + okq.size()));
        wr_busy = 1'b1;
        repeat (4) @(negedge clock);
        chk1(1'b1, active);
        wr_busy = 1'b0;
        repeat (4) @(negedge clock);
        chk1(1'b0, active);
        $display("test unarmed and standby done");
        for (int f = 0; f < 8; f++) frame(f % 2, f % 4, (f % 3 == 2) ? 3 : 0, f == 5 || f == 6);
        chk1(1'b0, saw_oe);
        // Back-to-back requests at the boundaries of each area, then random addresses.
        for (int w = 0; w < 2; w++) begin
            wp_n = 1'(w);
            repeat (4) @(negedge clock);
            for (int i = 0; i < 40; i++) begin
                bp = 3'(i % 8);
                wr_addr = (i < 8) ? base_of(bp) : (i < 16) ? base_of(bp) - 19'h1 : 19'($urandom);
                wr_req = 1'b1;
                @(negedge clock);
                chk({7'h00, prot(wp_n, bp, wr_addr)}, {7'h00, wr_blocked, wr_go});
            end
            wr_req = 1'b0;
            @(negedge clock);
            chk(9'h000, {7'h00, wr_blocked, wr_go});
        end
        $display("test protection done");
        tally_and_finish();
    end
    // Watchdog well beyond the expected run of about 1300 cycles.
    initial begin
        #400000;
        error_cnt++;
        tally_and_finish();
    end
endmodule // serial_flash_pin_interface_tb

// file: tb/sfpi_master.sv
// Behavioural bus master that drives the serial pins of the flash interface.
`timescale 1ns/100ps
module sfpi_master (
    input wire logic clock, // System clock, paces every pin change.
    output logic cs_n, // Chip select, active low.
    output logic sck, // Serial clock.
    output logic si, // Serial data towards the device.
    output logic hold_n, // Hold, active low.
    input wire logic so_pin // Resolved data-out wire.
);
    logic idle_lvl = 1'b0; // Clock rest level: low in mode 0, high in mode 3.
    // Select starts low so that a missing falling edge can be shown to be refused.
    initial begin
        cs_n = 1'b0;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end
    ////////////////////////////////////////////////////////////////
    // Four system clocks per level give the 160 ns serial period.
    task automatic half();
        repeat (4) @(negedge clock);
    endtask
    // Park the clock at its idle level, then select with a falling edge.
    task automatic start(input logic mode3);
        @(negedge clock);
        idle_lvl = mode3;
        sck = mode3;
        half();
        cs_n = 1'b0;
        half();
        half();
    endtask
    // Shift n bits MSB first; data-out is read late in the high phase, where it is settled.
    task automatic bits(input logic [7:0] d, input int n, output logic [7:0] q);
        q = 8'h00;
        for (int i = 0; i < n; i++) begin
            if (idle_lvl) sck = 1'b0;
            si = d[7 - i];
            half();
            sck = 1'b1;
            half();
            q = {q[6:0], so_pin};
            if (!idle_lvl) sck = 1'b0;
        end
    endtask
    // Hold with select kept low while the clock and data wiggle; an even count of toggles.
    // A half period passes first, so a clock edge just launched is taken before the hold.
    task automatic pause();
        half();
        hold_n = 1'b0;
        half();
        repeat (4) begin
            sck = ~sck;
            si = 1'($urandom);
            half();
        end
        hold_n = 1'b1;
        half();
    endtask
    // Deselect and return the clock to rest.
    task automatic stop();
        half();
        cs_n = 1'b1;
        sck = idle_lvl;
        half();
    endtask
endmodule // sfpi_master
